// File: hdl/sdpr_in_reg.sv
// input register with active-low load (hold when high)
`timescale 1ns/100ps
module sdpr_in_reg #(
  parameter int W = 9,
  parameter logic [W-1:0] RST = '0
)(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic register_hold_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      q <= RST;
    else if (!register_hold_n)
      q <= d;
  end
endmodule : sdpr_in_reg

// File: hdl/sdpr_mem.sv
// shared storage array, two write ports, two read ports
`timescale 1ns/100ps
module sdpr_mem #(
  parameter int AW = 12,
  parameter int DW = 9,
  parameter int DEPTH = 4096
)(
  input wire logic ref_clk,
  input wire logic [1:0] we,
  input wire logic [1:0][AW-1:0] waddr,
  input wire logic [1:0][DW-1:0] wdata,
  input wire logic [1:0][AW-1:0] raddr,
  output logic [1:0][DW-1:0] rdata
);
  logic [DW-1:0] mem [DEPTH];

  // port 1 wins a same-address collision
  always_ff @(posedge ref_clk)
  begin
    if (we[0])
      mem[waddr[0]] <= wdata[0];
    if (we[1])
      mem[waddr[1]] <= wdata[1];
  end

  assign rdata[0] = mem[raddr[0]];
  assign rdata[1] = mem[raddr[1]];
endmodule : sdpr_mem

// File: hdl/sdpr_pkg.sv
// constants shared by the dual-port ram port logic
package sdpr_pkg;
  localparam int NPORT = 2;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 9;
  localparam int DEPTH = 4096;
  localparam int WR_CYCLES = 1;
  localparam logic [ADDR_W-1:0] ADDR_RST = 12'h000;
  localparam logic [DATA_W-1:0] DATA_RST = 9'h000;
  typedef enum logic [1:0] {SDPR_IDLE, SDPR_READ, SDPR_WRITE} sdpr_op_t;
endpackage : sdpr_pkg

// File: hdl/sdpr_top.sv
// two-port synchronous ram: per-port registers, control and data lines
`timescale 1ns/100ps
module sdpr_top #(
  parameter int NP = sdpr_pkg::NPORT,
  parameter int AW = sdpr_pkg::ADDR_W,
  parameter int DW = sdpr_pkg::DATA_W,
  parameter int DEPTH = sdpr_pkg::DEPTH
)(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [NP-1:0] select_n,
  input wire logic [NP-1:0] write_n,
  input wire logic [NP-1:0] out_en_n,
  input wire logic [NP-1:0] register_hold_n,
  input wire logic [NP-1:0][AW-1:0] addr,
  input wire logic [NP-1:0][DW-1:0] data_lines_i,
  output logic [NP-1:0][DW-1:0] data_lines_o,
  output logic [NP-1:0] data_lines_oe,
  output logic [NP-1:0] standby
);
  import sdpr_pkg::*;

  // ----------------------------------------
  // shared array
  // ----------------------------------------
  logic [NP-1:0] mem_we;
  logic [NP-1:0][AW-1:0] mem_waddr;
  logic [NP-1:0][DW-1:0] mem_wdata;
  logic [NP-1:0][AW-1:0] rd_addr;
  logic [NP-1:0][DW-1:0] rd_word;
  logic [NP-1:0][AW-1:0] addr_reg;
  logic [NP-1:0][DW-1:0] din_reg;

  sdpr_mem #(
    .AW(AW),
    .DW(DW),
    .DEPTH(DEPTH)
  ) u_mem (
    .ref_clk(ref_clk),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .raddr(rd_addr),
    .rdata(rd_word)
  );

  // ----------------------------------------
  // per-port logic, identical for each port
  // ----------------------------------------
  for (genvar p = 0; p < NP; p++)
  begin : g_port
    sdpr_op_t op_reg;
    logic [DW-1:0] dout_reg;
    logic standby_reg;

    // ----------------------------------------
    // address and data input registers
    // ----------------------------------------
    sdpr_in_reg #(
      .W(AW),
      .RST(ADDR_RST)
    ) u_addr (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .register_hold_n(register_hold_n[p]),
      .d(addr[p]),
      .q(addr_reg[p])
    );

    sdpr_in_reg #(
      .W(DW),
      .RST(DATA_RST)
    ) u_din (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .register_hold_n(register_hold_n[p]),
      .d(data_lines_i[p]),
      .q(din_reg[p])
    );

    // ----------------------------------------
    // control register: operation of this cycle
    // ----------------------------------------
    always_ff @(posedge ref_clk)
    begin
      if (!nrst)
        op_reg <= SDPR_IDLE;
      else if (select_n[p])
        op_reg <= SDPR_IDLE;
      else if (write_n[p])
        op_reg <= SDPR_READ;
      else
        op_reg <= SDPR_WRITE;
    end

    // ----------------------------------------
    // standby after a deselected edge
    // ----------------------------------------
    always_ff @(posedge ref_clk)
    begin
      if (!nrst)
        standby_reg <= 1'b1;
      else
        standby_reg <= select_n[p];
    end

    // ----------------------------------------
    // read address: the value the register holds after this edge
    // ----------------------------------------
    assign rd_addr[p] = register_hold_n[p] ? addr_reg[p] : addr[p];

    // ----------------------------------------
    // read data register
    // ----------------------------------------
    always_ff @(posedge ref_clk)
    begin
      if (!nrst)
        dout_reg <= DATA_RST;
      else if (!select_n[p] && write_n[p])
        dout_reg <= rd_word[p];
    end

    // ----------------------------------------
    // write: begun at one edge, committed at the next
    // ----------------------------------------
    assign mem_we[p] = (op_reg == SDPR_WRITE);
    assign mem_waddr[p] = addr_reg[p];
    assign mem_wdata[p] = din_reg[p];

    // ----------------------------------------
    // data line drive, output enable is asynchronous
    // ----------------------------------------
    assign data_lines_oe[p] = (op_reg == SDPR_READ) && !out_en_n[p];
    assign data_lines_o[p] = dout_reg;
    assign standby[p] = standby_reg;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    AST_OE_FLOAT: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      out_en_n[p] |-> !data_lines_oe[p])
      else $error("data lines driven with output enable high");

    AST_RD_DRIVE: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      (!select_n[p] && write_n[p]) |=> (data_lines_oe[p] == !out_en_n[p]))
      else $error("read did not drive data lines");

    AST_RD_WORD: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      (!select_n[p] && write_n[p]) |=> (data_lines_o[p] == $past(rd_word[p])))
      else $error("read word not returned intact");

    AST_WR_START: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      (!select_n[p] && !write_n[p] && !register_hold_n[p])
        |=> (mem_we[p] && mem_waddr[p] == $past(addr[p])
             && mem_wdata[p] == $past(data_lines_i[p])))
      else $error("write not started with sampled address and data");

    AST_WR_END: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      (!select_n[p] && !write_n[p]) ##1 select_n[p] |=> !mem_we[p])
      else $error("write pulse outlived the next edge");

    AST_WR_NO_DRIVE: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      (!select_n[p] && !write_n[p]) |=> !data_lines_oe[p])
      else $error("data lines driven during write");

    AST_HOLD: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      register_hold_n[p] |=> ($stable(addr_reg[p]) && $stable(din_reg[p])))
      else $error("input registers changed while held");

    AST_LOAD: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      !register_hold_n[p]
        |=> (addr_reg[p] == $past(addr[p]) && din_reg[p] == $past(data_lines_i[p])))
      else $error("input registers failed to load pins");

    AST_DESELECT: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      select_n[p] |=> (standby[p] && !data_lines_oe[p] && !mem_we[p]))
      else $error("deselect did not float and stand by");

    AST_WAKE: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      $fell(standby[p]) |-> !$past(select_n[p]))
      else $error("standby ended without a selected edge");

    AST_REG_ADDR: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      mem_we[p] |-> (mem_waddr[p] == addr_reg[p]))
      else $error("write used live address");
  end

endmodule : sdpr_top

// File: verification/sdpr_bus_model.sv
// wire model of one port's data lines with the controller beside it
`timescale 1ns/100ps
module sdpr_bus_model (
  input wire logic ref_clk,
  input wire logic [sdpr_pkg::DATA_W-1:0] dev_o,
  input wire logic dev_oe,
  input wire logic [sdpr_pkg::DATA_W-1:0] host_d,
  input wire logic host_oe,
  output logic [sdpr_pkg::DATA_W-1:0] bus
);
  import sdpr_pkg::*;
  logic [DATA_W-1:0] last_reg = 9'h000;
  // released lines keep changing, never a stale word
  assign bus = dev_oe ? dev_o : (host_oe ? host_d : ~last_reg);
  always_ff @(posedge ref_clk)
  begin
    last_reg <= bus;
  end
endmodule : sdpr_bus_model

// File: verification/tb_sdpr_top.sv
// self-checking bench for the dual-port ram port logic
`timescale 1ns/100ps
module tb_sdpr_top;
  import sdpr_pkg::*;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic [1:0] select_n = 2'b11;
  logic [1:0] write_n = 2'b11;
  logic [1:0] out_en_n = 2'b11;
  logic [1:0] register_hold_n = 2'b00;
  logic [1:0][ADDR_W-1:0] addr = '0;
  logic [1:0][DATA_W-1:0] host_d = '0;
  logic [1:0][DATA_W-1:0] data_lines_i;
  logic [1:0][DATA_W-1:0] data_lines_o;
  logic [1:0] data_lines_oe;
  logic [1:0] standby;
  logic [1:0] rd_seen;
  logic [DATA_W-1:0] ref_mem [DEPTH];
  logic [ADDR_W-1:0] held [2];
  logic [DATA_W:0] expq [2][$];
  logic [31:0] seed = 32'h01b38c7d;
  int n_errors = 0;
  int tests_run = 0;
  always #50 ref_clk = ~ref_clk;
  sdpr_top u_dut (.ref_clk(ref_clk), .nrst(nrst), .select_n(select_n), .write_n(write_n),
    .out_en_n(out_en_n), .register_hold_n(register_hold_n), .addr(addr),
    .data_lines_i(data_lines_i), .data_lines_o(data_lines_o),
    .data_lines_oe(data_lines_oe), .standby(standby));
  for (genvar p = 0; p < 2; p++)
  begin : g_bus
    sdpr_bus_model u_bus (.ref_clk(ref_clk), .dev_o(data_lines_o[p]),
      .dev_oe(data_lines_oe[p]), .host_d(host_d[p]),
      .host_oe(!write_n[p] && !select_n[p]), .bus(data_lines_i[p]));
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // set one port's pins and note the expected outcome
  task automatic put(input int p, input logic sn, wn, oen, hn, input logic [11:0] a);
    seed = lfsr(seed);
    select_n[p] = sn;
    write_n[p] = wn;
    out_en_n[p] = oen;
    register_hold_n[p] = hn;
    addr[p] = a;
    host_d[p] = seed[8:0];
    if (!hn) held[p] = a;
    if (!sn && !wn) ref_mem[held[p]] = seed[8:0];
    if (!sn && wn) expq[p].push_back({!oen, ref_mem[held[p]]});
  endtask : put
  task automatic results;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : results
  // read results appear 1 ns after the edge that takes the read
  always @(posedge ref_clk)
  begin
    rd_seen = ~select_n & write_n & {2{nrst}};
    #1;
    for (int p = 0; p < 2; p++)
      if (rd_seen[p])
        if (expq[p].size() == 0) chk("read queue", 10'h000, 10'h3ff);
        else chk("read word", expq[p].pop_front(), {data_lines_oe[p], data_lines_o[p]});
  end
  initial
  begin
    repeat (20) @(negedge ref_clk);
    nrst = 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      @(negedge ref_clk);
      put(0, 0, 0, 1, 0, 12'(i));
      put(1, 0, 0, 1, 0, 12'hff8 + 12'(i));
    end
    for (int i = 0; i < 8; i++)
    begin
      @(negedge ref_clk);
      put(0, 0, 1, 0, 0, 12'hff8 + 12'(i));
      put(1, 0, 1, i[0], 0, 12'(i));
    end
    $display("test crossed write and read done");
    @(negedge ref_clk);
    put(0, 1, 1, 0, 0, 12'h000);
    put(1, 1, 0, 0, 0, 12'h001);
    @(posedge ref_clk);
    #1;
    chk("standby", 10'h003, {8'h00, standby});
    chk("drive", 10'h000, {8'h00, data_lines_oe});
    $display("test deselect done");
    @(negedge ref_clk);
    put(0, 0, 0, 1, 0, 12'h100);
    @(negedge ref_clk);
    put(0, 1, 1, 1, 1, 12'h200);
    @(negedge ref_clk);
    put(0, 0, 1, 0, 1, 12'h300);
    put(1, 0, 1, 0, 0, 12'h001);
    @(negedge ref_clk);
    put(0, 1, 1, 1, 1, 12'h000);
    put(1, 1, 1, 1, 1, 12'h000);
    repeat (2) @(negedge ref_clk);
    chk("leftover", 10'h000, 10'(expq[0].size() + expq[1].size()));
    $display("test register hold done");
    results();
  end
endmodule : tb_sdpr_top
